// [timer16_ctrl_capture_compare.sv]
// 16-bit timer/counter channel with capture, compare A and force strobes
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module timer16_ctrl_capture_compare
    import timer16_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire reg_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic capture_input_pin,
    input wire logic ext_count_pin,
    output logic compare_output_a,
    output logic compare_output_a_en
);
    logic [1:0] compare_out_mode_a_q;
    logic [3:0] waveform_mode_q;
    logic [2:0] clock_select_q;
    logic capture_filter_enable_q;
    logic capture_edge_select_q;
    logic [15:0] counter_value_q;
    logic [15:0] compare_value_a_q;
    logic [15:0] capture_value_reg_q;
    logic [7:0] temp_q;
    logic [7:0] rdata_q;
    logic [2:0] status_q;
    logic up_q;
    logic block_q;
    logic oc_q;
    logic [9:0] presc_q;
    logic cap_s1_q, cap_s2_q;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic [FILTER_LEN-1:0] hist_q;
    logic filt_q;
    logic cap_prev_q;

    mode_class_t mclass;
    logic [15:0] top;
    logic icr_top;
    logic tick;
    logic cap_level;
    logic cap_evt;
    logic match_a;
    logic wr_cnt;
    logic force_a;
    logic at_top;
    logic at_bottom;
    logic tov_evt;

    function automatic logic hit(input logic [7:0] ofs, input logic stb);
        hit = stb && (bus_req.addr == ofs);
    endfunction

    function automatic mode_class_t class_of(input logic [3:0] m);
        unique case (m)
            4'h0, 4'h4, 4'hC, 4'hD: class_of = CLASS_NONPWM; // [RULE6]
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: class_of = CLASS_FAST; // [RULE7] [RULE10]
            default: class_of = CLASS_PHASE; // [RULE8] [RULE9]
        endcase
    endfunction

    // Reserved mode 13 is run as plain normal counting
    always_comb begin
        mclass = class_of(waveform_mode_q);
        icr_top = 1'b0;
        unique case (waveform_mode_q)
            4'h1, 4'h5: top = TOP_8BIT; // [RULE7]
            4'h2, 4'h6: top = TOP_9BIT; // [RULE7]
            4'h3, 4'h7: top = TOP_10BIT; // [RULE7]
            4'h4, 4'hC, 4'h9, 4'hB, 4'hF: top = compare_value_a_q; // [RULE6]
            4'h8, 4'hA, 4'hE: begin
                top = capture_value_reg_q; // [RULE8] [RULE9] [RULE10]
                icr_top = 1'b1;
            end
            default: top = MAX_VAL; // [RULE6] [RULE10]
        endcase
    end

    // Prescaler runs free; each tap is a one-cycle enable
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 10'h001;
        end
    end

    // Pin synchronisers; pin read whatever its port direction
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            cap_s1_q <= 1'b0;
            cap_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_count_pin; // [RULE13]
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            cap_s1_q <= capture_input_pin;
            cap_s2_q <= cap_s1_q;
        end
    end

    always_comb begin
        unique case (clock_select_q)
            CS_STOP: tick = 1'b0; // [RULE11]
            CS_DIV1: tick = 1'b1; // [RULE11]
            CS_DIV8: tick = (presc_q & DIV8_MASK) == DIV8_MASK;
            CS_DIV64: tick = (presc_q & DIV64_MASK) == DIV64_MASK;
            CS_DIV256: tick = (presc_q & DIV256_MASK) == DIV256_MASK;
            CS_DIV1024: tick = presc_q == DIV1024_MASK; // [RULE11]
            CS_EXT_FALL: tick = ext_s3_q && !ext_s2_q; // [RULE12]
            CS_EXT_RISE: tick = !ext_s3_q && ext_s2_q; // [RULE12]
        endcase
    end

    // Noise filter: output moves only on a full run of equal samples
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            hist_q <= '0;
            filt_q <= 1'b0;
        end else begin
            hist_q <= {hist_q[FILTER_LEN-2:0], cap_s2_q};
            if (&hist_q) begin
                filt_q <= 1'b1; // [RULE1]
            end else if (~|hist_q) begin
                filt_q <= 1'b0; // [RULE1]
            end
        end
    end

    assign cap_level = capture_filter_enable_q ? filt_q : cap_s2_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cap_prev_q <= 1'b0;
        end else begin
            cap_prev_q <= cap_level;
        end
    end

    // Capture pin is cut off while the capture register sets TOP
    assign cap_evt = !icr_top && // [RULE4]
        (capture_edge_select_q ? (cap_level && !cap_prev_q)
                               : (!cap_level && cap_prev_q)); // [RULE2]

    assign wr_cnt = hit(OFS_CNT_LO, bus_req.wr);
    assign force_a = hit(OFS_FORCE, bus_req.wr) &&
        bus_req.wdata[BIT_FORCE_A] && mclass == CLASS_NONPWM; // [RULE14]
    assign match_a = counter_value_q == compare_value_a_q && !block_q; // [RULE19] [RULE18]
    assign at_top = counter_value_q == top;
    assign at_bottom = counter_value_q == RST_WORD;
    assign tov_evt = tick && (mclass == CLASS_PHASE ? (at_bottom && !up_q)
        : (mclass == CLASS_FAST ? at_top : counter_value_q == MAX_VAL));

    // Control registers; reserved bit 5 of control B is never stored
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            compare_out_mode_a_q <= COM_OFF;
            waveform_mode_q <= '0;
            clock_select_q <= CS_STOP;
            capture_filter_enable_q <= 1'b0;
            capture_edge_select_q <= 1'b0;
        end else begin
            if (hit(OFS_CTRL_A, bus_req.wr)) begin
                compare_out_mode_a_q <= bus_req.wdata[7:6];
                waveform_mode_q[1:0] <= bus_req.wdata[1:0];
            end
            if (hit(OFS_CTRL_B, bus_req.wr)) begin
                capture_filter_enable_q <= bus_req.wdata[BIT_FILT];
                capture_edge_select_q <= bus_req.wdata[BIT_EDGE];
                waveform_mode_q[3:2] <= bus_req.wdata[4:3]; // [RULE5]
                clock_select_q <= bus_req.wdata[2:0];
            end
        end
    end

    // Shared high byte: latched on counter or compare A high writes and on counter or capture low reads
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            temp_q <= RST_BYTE;
        end else if (hit(OFS_CNT_HI, bus_req.wr) ||
                     hit(OFS_CMPA_HI, bus_req.wr)) begin
            temp_q <= bus_req.wdata; // [RULE17] [RULE21]
        end else if (hit(OFS_CNT_LO, bus_req.rd)) begin
            temp_q <= counter_value_q[15:8]; // [RULE17]
        end else if (hit(OFS_CAP_LO, bus_req.rd)) begin
            temp_q <= capture_value_reg_q[15:8]; // [RULE17]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            compare_value_a_q <= RST_WORD;
        end else if (hit(OFS_CMPA_LO, bus_req.wr)) begin
            compare_value_a_q <= {temp_q, bus_req.wdata}; // [RULE17]
        end
    end

    // Counter sequencing; a software write outranks the tick
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            counter_value_q <= RST_WORD;
            up_q <= 1'b1;
        end else if (wr_cnt) begin
            counter_value_q <= {temp_q, bus_req.wdata}; // [RULE17]
        end else if (tick) begin
            unique case (mclass)
                CLASS_PHASE: begin
                    if (up_q && at_top) begin
                        up_q <= 1'b0;
                        counter_value_q <= counter_value_q - 16'h0001;
                    end else if (!up_q && at_bottom) begin
                        up_q <= 1'b1;
                        counter_value_q <= counter_value_q + 16'h0001;
                    end else if (up_q) begin
                        counter_value_q <= counter_value_q + 16'h0001;
                    end else begin
                        counter_value_q <= counter_value_q - 16'h0001;
                    end
                end
                default: begin
                    up_q <= 1'b1;
                    // Only a real match at TOP clears; a forced one cannot
                    counter_value_q <= at_top ? RST_WORD
                        : counter_value_q + 16'h0001; // [RULE6] [RULE15]
                end
            endcase
        end
    end

    // Match blocking lasts until the next timer clock
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            block_q <= 1'b0;
        end else if (wr_cnt) begin
            block_q <= 1'b1; // [RULE18]
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            capture_value_reg_q <= RST_WORD;
        end else if (cap_evt) begin
            capture_value_reg_q <= counter_value_q; // [RULE3]
        end
    end

    // Flags: hardware set wins over a same-cycle write-one clear
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            status_q <= '0;
        end else begin
            if (hit(OFS_STATUS, bus_req.wr)) begin
                status_q <= status_q & ~{bus_req.wdata[BIT_CAPF],
                    bus_req.wdata[BIT_OCFA], bus_req.wdata[BIT_TOV]};
            end
            if (cap_evt) begin
                status_q[2] <= 1'b1; // [RULE3]
            end
            if (tick && match_a) begin
                status_q[1] <= 1'b1; // [RULE19] [RULE15]
            end
            if (tov_evt) begin
                status_q[0] <= 1'b1;
            end
        end
    end

    // Waveform output for channel A
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            oc_q <= 1'b0;
        end else if (force_a || (tick && match_a &&
                     mclass == CLASS_NONPWM)) begin
            unique case (compare_out_mode_a_q)
                COM_TOGGLE: oc_q <= !oc_q; // [RULE20] [RULE14]
                COM_CLEAR: oc_q <= 1'b0; // [RULE20]
                COM_SET: oc_q <= 1'b1; // [RULE20]
                COM_OFF: oc_q <= oc_q; // [RULE20]
            endcase
        end else if (tick && mclass == CLASS_FAST) begin
            if (match_a) begin
                oc_q <= compare_out_mode_a_q == COM_SET; // [RULE19]
            end else if (at_top) begin
                oc_q <= compare_out_mode_a_q != COM_SET;
            end
        end else if (tick && mclass == CLASS_PHASE && match_a) begin
            oc_q <= (compare_out_mode_a_q == COM_SET) == up_q; // [RULE19]
        end
    end

    assign compare_output_a = oc_q && compare_out_mode_a_q != COM_OFF;
    assign compare_output_a_en = compare_out_mode_a_q != COM_OFF;

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata_q <= RST_BYTE;
        end else if (!bus_req.rd) begin
            rdata_q <= RST_BYTE;
        end else begin
            unique case (bus_req.addr)
                OFS_CTRL_A: rdata_q <= {compare_out_mode_a_q, 4'h0,
                    waveform_mode_q[1:0]};
                OFS_CTRL_B: rdata_q <= {capture_filter_enable_q,
                    capture_edge_select_q, 1'b0, waveform_mode_q[3:2],
                    clock_select_q}; // [RULE5]
                OFS_FORCE: rdata_q <= RST_BYTE; // [RULE16]
                OFS_CNT_LO: rdata_q <= counter_value_q[7:0];
                OFS_CNT_HI, OFS_CAP_HI: rdata_q <= temp_q; // [RULE17]
                OFS_CAP_LO: rdata_q <= capture_value_reg_q[7:0];
                OFS_CMPA_LO: rdata_q <= compare_value_a_q[7:0];
                OFS_CMPA_HI: rdata_q <= compare_value_a_q[15:8];
                OFS_STATUS: rdata_q <= {2'h0, status_q[2], 3'h0,
                    status_q[1], status_q[0]};
                default: rdata_q <= RST_BYTE;
            endcase
        end
    end

    assign rdata = rdata_q;

    sequence s_cnt_write;
        hit(OFS_CNT_LO, bus_req.wr);
    endsequence

    a_filter_four_samples: assert property (@(posedge sys_clk) // [RULE1]
        disable iff (!reset_n) $rose(filt_q) |-> &$past(hist_q))
        else $error("filter rose without four equal samples");

    a_capture_copies_count: assert property (@(posedge sys_clk) // [RULE3]
        disable iff (!reset_n) cap_evt |=> capture_value_reg_q ==
        $past(counter_value_q) && status_q[2])
        else $error("capture did not copy counter or set flag");

    a_icr_top_blocks: assert property (@(posedge sys_clk) // [RULE4]
        disable iff (!reset_n) icr_top |-> !cap_evt)
        else $error("capture while capture register is TOP");

    a_reserved_reads_zero: assert property (@(posedge sys_clk) // [RULE5]
        disable iff (!reset_n) hit(OFS_CTRL_B, bus_req.rd) |=> !rdata[5])
        else $error("reserved bit read as one");

    a_force_reads_zero: assert property (@(posedge sys_clk) // [RULE16]
        disable iff (!reset_n) hit(OFS_FORCE, bus_req.rd) |=> rdata == 8'h00)
        else $error("force register read non-zero");

    a_stopped_holds: assert property (@(posedge sys_clk) // [RULE11]
        disable iff (!reset_n) clock_select_q == CS_STOP && !wr_cnt |=>
        $stable(counter_value_q))
        else $error("stopped counter moved");

    a_write_blocks_match: assert property (@(posedge sys_clk) // [RULE18]
        disable iff (!reset_n) s_cnt_write ##1 (!tick && !wr_cnt)[*2] |->
        block_q && !match_a)
        else $error("match not blocked after counter write");

    a_force_no_flag: assert property (@(posedge sys_clk) // [RULE15]
        disable iff (!reset_n) force_a && !(tick && match_a) |=>
        status_q[1] == $past(status_q[1]))
        else $error("forced compare set the match flag");

    a_cap_set_wins: assert property (@(posedge sys_clk) // [RULE3]
        disable iff (!reset_n) cap_evt && hit(OFS_STATUS, bus_req.wr) |=>
        status_q[2])
        else $error("capture flag lost to clear");
endmodule
`default_nettype wire

// [timer16_pkg.sv]
// Constants, register map and types for the 16-bit timer channel
// Overview of operation
// RULE1 - Filter output changes only after four equal consecutive pin samples
// RULE2 - Edge select zero captures on falling edge, one on rising
// RULE3 - Capture copies counter into capture register and sets capture flag
// RULE4 - Modes using capture register as TOP disable input capture
// RULE5 - Control B bit 5 reads zero and ignores writes
// RULE6 - Mode 0 normal; modes 4 and 12 clear on compare A
// RULE7 - Modes 1-3 phase PWM, 5-7 fast PWM, fixed 8/9/10-bit TOP
// RULE8 - Modes 8, 9 phase-frequency PWM, TOP capture or compare A
// RULE9 - Modes 10, 11 phase PWM, TOP capture or compare A
// RULE10 - Modes 14, 15 fast PWM, TOP capture or compare A; 13 reserved
// RULE11 - Clock select 0 stops, 1 direct, 2-5 divide 8/64/256/1024
// RULE12 - Clock select 6, 7 count external pin falling or rising edges
// RULE13 - External pin counts even while driven as an output
// RULE14 - Force compare acts only in non-PWM modes, per output mode bits
// RULE15 - Forced compare raises no flag and never clears the counter
// RULE16 - Force compare bits are strobes and read zero
// RULE17 - 16-bit registers go through one shared temporary high byte
// RULE18 - Counter write blocks compare match on next timer clock
// RULE19 - Compare register compared continuously; match flags and drives output
// RULE20 - Non-PWM output modes: off, toggle, clear, set
// RULE21 - Software writes high byte first, reads low byte first
package timer16_pkg;
    localparam int CNT_W = 16;
    localparam logic [7:0] OFS_CTRL_A = 8'h90;
    localparam logic [7:0] OFS_CTRL_B = 8'h91;
    localparam logic [7:0] OFS_FORCE = 8'h92;
    localparam logic [7:0] OFS_CNT_LO = 8'h94;
    localparam logic [7:0] OFS_CNT_HI = 8'h95;
    localparam logic [7:0] OFS_CAP_LO = 8'h96;
    localparam logic [7:0] OFS_CAP_HI = 8'h97;
    localparam logic [7:0] OFS_CMPA_LO = 8'h98;
    localparam logic [7:0] OFS_CMPA_HI = 8'h99;
    localparam logic [7:0] OFS_STATUS = 8'hA0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam int BIT_FILT = 7;
    localparam int BIT_EDGE = 6;
    localparam int BIT_FORCE_A = 7;
    localparam int BIT_TOV = 0;
    localparam int BIT_OCFA = 1;
    localparam int BIT_CAPF = 5;
    localparam int FILTER_LEN = 4;
    localparam logic [15:0] MAX_VAL = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03F;
    localparam logic [9:0] DIV256_MASK = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef enum logic [1:0] {
        CLASS_NONPWM,
        CLASS_FAST,
        CLASS_PHASE
    } mode_class_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

// [tb.sv]
// Self-checking bench for the 16-bit timer channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("MISMATCH t=%0t %s", $time, msg); \
        end \
    end
module tb;
    import timer16_pkg::*;
    typedef struct packed {logic chk; logic [7:0] val;} note_t;
    logic sys_clk;
    logic reset_n;
    reg_req_t bus_req;
    logic [7:0] rdata;
    logic capture_input_pin;
    logic ext_count_pin;
    logic compare_output_a;
    logic compare_output_a_en;
    note_t notes[$];
    note_t nt;
    logic rd_seen;
    logic [7:0] last_rd;
    int fail_count;
    int n_tests;
    logic [15:0] w;
    logic [15:0] w2;
    logic [15:0] c;
    logic [3:0] m;
    int divs[5] = '{1, 8, 64, 256, 1024};
    logic [1:0] com_seq[4] = '{2'h1, 2'h1, 2'h3, 2'h2};
    logic exp_seq[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    timer16_ctrl_capture_compare timer16_ctrl_capture_compare_i (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .bus_req(bus_req),
        .rdata(rdata),
        .capture_input_pin(capture_input_pin),
        .ext_count_pin(ext_count_pin),
        .compare_output_a(compare_output_a),
        .compare_output_a_en(compare_output_a_en)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk) rd_seen <= bus_req.rd & reset_n;
    always @(negedge sys_clk) begin
        if (rd_seen === 1'b1) begin
            last_rd = rdata;
            if (notes.size() == 0) begin
                `CHK(1'b1, 1'b0, "read without note")
            end else begin
                nt = notes.pop_front();
                if (nt.chk) `CHK(rdata, nt.val, "read data")
            end
        end
    end

    task automatic bus(input logic [7:0] a, input logic [7:0] d,
                       input logic w_en);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: w_en, rd: ~w_en};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        notes.push_back('{chk: 1'b1, val: e});
        bus(a, 8'h00, 1'b0);
    endtask
    task automatic wr16(input logic [7:0] hi, input logic [15:0] v);
        wr(hi, v[15:8]);
        wr(hi - 8'h01, v[7:0]);
    endtask
    task automatic rd16(input logic [7:0] lo, input logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 8'h01, v[15:8]);
    endtask
    // Two reads exactly span cycles apart; delta is the count advance
    task automatic rd_span(input logic [7:0] a, input int span,
                           input logic [7:0] dl);
        notes.push_back('{chk: 1'b0, val: 8'h00});
        bus(a, 8'h00, 1'b0);
        repeat (span - 1) @(posedge sys_clk);
        notes.push_back('{chk: 1'b1, val: last_rd + dl});
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask
    task automatic pin(input logic v, input int n);
        @(posedge sys_clk);
        capture_input_pin <= v;
        repeat (n) @(posedge sys_clk);
    endtask
    // Margin covers the strobe register and output flop
    task automatic out_chk(input logic e);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(compare_output_a, e, "compare output a")
    endtask
    task automatic done_test(input string name);
        repeat (2) @(posedge sys_clk);
        $display("test %s done", name);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #400000;
        fail_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        summarize();
    end

    initial begin
        reset_n = 1'b0;
        bus_req = '0;
        capture_input_pin = 1'b0;
        ext_count_pin = 1'b0;
        fail_count = 0;
        n_tests = 0;
        void'($urandom(32'h03BBB87F));
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(OFS_FORCE, RST_BYTE);
        rd16(OFS_CNT_LO, RST_WORD);
        rd(OFS_CMPA_HI, RST_BYTE);
        rd(OFS_CTRL_B, RST_BYTE);
        wr(8'h9F, 8'h5A);
        rd(8'h9F, 8'h00);
        done_test("reset");
        for (int i = 0; i < 16; i++) begin
            m = 4'(i);
            wr(OFS_CTRL_A, {6'h00, m[1:0]});
            wr(OFS_CTRL_B, {3'b001, m[3:2], 3'b000});
            rd(OFS_CTRL_B, {3'b000, m[3:2], 3'b000});
            rd(OFS_CTRL_A, {6'h00, m[1:0]});
        end
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_FORCE, 8'hE0);
        rd(OFS_FORCE, 8'h00);
        done_test("modes");
        w = 16'($urandom);
        c = (16'($urandom) & 16'h7FFF) | 16'h0100;
        wr16(OFS_CNT_HI, w);
        rd16(OFS_CNT_LO, w);
        wr16(OFS_CMPA_HI, c);
        rd16(OFS_CMPA_LO, c);
        // Lone high write only fills the shared temp byte
        wr(OFS_CMPA_HI, 8'hAB);
        rd(OFS_CMPA_HI, c[15:8]);
        wr(OFS_CNT_LO, 8'h01);
        rd16(OFS_CNT_LO, 16'hAB01);
        done_test("sixteen bit");
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CTRL_B, {5'b0, 3'(i + 1)});
            rd_span(OFS_CNT_LO, 4 * divs[i], 8'h04);
        end
        wr(OFS_CTRL_B, 8'h00);
        rd_span(OFS_CNT_LO, 20, 8'h00);
        for (int cs = 6; cs < 8; cs++) begin
            wr16(OFS_CNT_HI, 16'h0000);
            wr(OFS_CTRL_B, {5'b0, 3'(cs)});
            for (int k = 0; k < 5; k++) begin
                @(posedge sys_clk);
                ext_count_pin <= 1'b1;
                repeat (4) @(posedge sys_clk);
                ext_count_pin <= 1'b0;
                repeat (4) @(posedge sys_clk);
            end
            repeat (6) @(posedge sys_clk);
            rd(OFS_CNT_LO, 8'h05);
            wr(OFS_CTRL_B, 8'h00);
        end
        done_test("clock select");
        wr(OFS_STATUS, 8'hFF);
        rd(OFS_STATUS, 8'h00);
        wr(OFS_CTRL_B, 8'h40);
        wr16(OFS_CNT_HI, w);
        pin(1'b1, 8);
        rd16(OFS_CAP_LO, w);
        rd(OFS_STATUS, 8'h20);
        wr(OFS_STATUS, 8'hFF);
        wr(OFS_CTRL_B, 8'h00);
        w2 = w ^ 16'h5A5A;
        wr16(OFS_CNT_HI, w2);
        pin(1'b0, 8);
        rd16(OFS_CAP_LO, w2);
        wr16(OFS_CNT_HI, ~w);
        pin(1'b1, 8);
        rd(OFS_CAP_LO, w2[7:0]);
        wr(OFS_CTRL_B, 8'h40);
        pin(1'b0, 8);
        // Three equal samples are not enough for the filter
        wr(OFS_CTRL_B, 8'hC0);
        wr16(OFS_CNT_HI, c);
        pin(1'b1, 2);
        pin(1'b0, 10);
        rd(OFS_CAP_LO, w2[7:0]);
        pin(1'b1, 12);
        rd16(OFS_CAP_LO, c);
        pin(1'b0, 8);
        wr(OFS_STATUS, 8'hFF);
        wr(OFS_CTRL_A, 8'h02);
        wr(OFS_CTRL_B, 8'h58);
        wr16(OFS_CNT_HI, w);
        pin(1'b1, 8);
        rd(OFS_CAP_LO, c[7:0]);
        rd(OFS_STATUS, 8'h00);
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_CTRL_B, 8'h00);
        done_test("capture");
        @(negedge sys_clk);
        `CHK(compare_output_a_en, 1'b0, "output enable off")
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CTRL_A, {com_seq[k], 6'h00});
            wr(OFS_FORCE, 8'h80);
            out_chk(exp_seq[k]);
            `CHK(compare_output_a_en, 1'b1, "output enable on")
        end
        rd(OFS_STATUS, 8'h00);
        wr(OFS_CTRL_B, 8'h08);
        wr16(OFS_CNT_HI, c ^ 16'h0F0F);
        wr(OFS_FORCE, 8'h80);
        rd16(OFS_CNT_LO, c ^ 16'h0F0F);
        wr(OFS_CTRL_A, 8'h41);
        wr(OFS_FORCE, 8'h80);
        out_chk(1'b0);
        wr(OFS_CTRL_A, 8'hC0);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_STATUS, 8'hFF);
        wr16(OFS_CNT_HI, c - 16'h0003);
        wr(OFS_CTRL_B, 8'h01);
        repeat (10) @(posedge sys_clk);
        wr(OFS_CTRL_B, 8'h00);
        out_chk(1'b1);
        rd(OFS_STATUS, 8'h02);
        // Written value equals compare, so only blocking avoids a match
        wr(OFS_CTRL_A, 8'h40);
        wr(OFS_STATUS, 8'hFF);
        wr16(OFS_CNT_HI, c);
        wr(OFS_CTRL_B, 8'h01);
        repeat (8) @(posedge sys_clk);
        wr(OFS_CTRL_B, 8'h00);
        out_chk(1'b1);
        rd(OFS_STATUS, 8'h00);
        // Fixed 8-bit TOP: fast wraps to zero, phase turns back down
        wr(OFS_CTRL_A, 8'h01);
        wr(OFS_STATUS, 8'hFF);
        wr16(OFS_CNT_HI, 16'h00FD);
        wr(OFS_CTRL_B, 8'h09);
        repeat (4) @(posedge sys_clk);
        wr(OFS_CTRL_B, 8'h08);
        rd16(OFS_CNT_LO, 16'h0003);
        rd(OFS_STATUS, 8'h01);
        wr16(OFS_CNT_HI, 16'h00FD);
        wr(OFS_CTRL_B, 8'h01);
        repeat (4) @(posedge sys_clk);
        wr(OFS_CTRL_B, 8'h00);
        rd16(OFS_CNT_LO, 16'h00FB);
        done_test("compare");
        repeat (5) @(posedge sys_clk);
        `CHK(notes.size(), 0, "reads left unanswered")
        summarize();
    end
endmodule
`default_nettype wire
